//--- common/interrupt_context_return_defs.vh
// constants for the interrupt entry and return block
// assumes the including core runs every register on one clock
//
// How it works
// - interrupt redirects fetch to address 000h
// - opcode 00e restores context from shadows
// - status flags take saved value, not computed
// - return resumes at restored 12-bit pc
// - opcode 00f is counter-adjusting return
// - add accumulator into counter before restore
// - returns take 2 cycles compatible, 3 turbo
`ifndef INTERRUPT_CONTEXT_RETURN_DEFS_VH
`define INTERRUPT_CONTEXT_RETURN_DEFS_VH

`define ICR_VECTOR_ADDR   12'h000
`define ICR_OP_RETURN     12'h00e
`define ICR_OP_RETURN_ADJ 12'h00f
`define ICR_CYC_COMPAT    2'h2
`define ICR_CYC_TURBO     2'h3
`define ICR_RST_PC        12'h000
`define ICR_RST_BYTE      8'h00
`define ICR_RST_CNT       2'h0
`define ICR_RST_BIT       1'b0

`endif

//--- core/interrupt_context_return.v
// interrupt entry and return-from-interrupt sequencing for the core
// assumes all inputs come from core logic on clk; no pins reach here
`timescale 1ns/1ps
`include "interrupt_context_return_defs.vh"

module interrupt_context_return (
    // clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // timing mode: high selects turbo
    input  wire        turboMode,
    // interrupt entry
    input  wire        irqTake,
    // live core state
    input  wire [11:0] pcIn,
    input  wire [7:0]  accIn,
    input  wire [7:0]  statusIn,
    input  wire [7:0]  fileSelectIn,
    input  wire [7:0]  realTimeCounterIn,
    // decoded instruction
    input  wire        opValid,
    input  wire [11:0] opcode,
    // fetch redirect
    output reg         fetchLoad,
    output reg  [11:0] fetchAddr,
    // context restore
    output reg         restoreLoad,
    output reg  [7:0]  accOut,
    output reg  [7:0]  statusOut,
    output reg  [7:0]  fileSelectOut,
    // counter adjust
    output reg         realTimeCounterLoad,
    output reg  [7:0]  realTimeCounterOut,
    // return sequence in progress
    output reg         busy
);

    // one-hot sequencer states
    localparam [1:0] ST_IDLE   = 2'b01;
    localparam [1:0] ST_RETURN = 2'b10;

    // sequencer state and cycles left in a return
    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [1:0]  cnt_reg;
    reg  [1:0]  cnt_next;

    // shadow copies of the interrupted context
    reg  [11:0] shadowPc_reg;
    reg  [11:0] shadowPc_next;
    reg  [7:0]  shadowAcc_reg;
    reg  [7:0]  shadowAcc_next;
    reg  [7:0]  shadowStatus_reg;
    reg  [7:0]  shadowStatus_next;
    reg  [7:0]  shadowPointer_reg;
    reg  [7:0]  shadowPointer_next;

    // next values of the registered outputs
    reg         fetchLoad_next;
    reg  [11:0] fetchAddr_next;
    reg         restoreLoad_next;
    reg  [7:0]  accOut_next;
    reg  [7:0]  statusOut_next;
    reg  [7:0]  fileSelectOut_next;
    reg         realTimeCounterLoad_next;
    reg  [7:0]  realTimeCounterOut_next;
    reg         busy_next;

    // decode and sequencing qualifiers
    wire        isIdle;
    wire        isReturn;
    wire        isReturnAdj;
    wire        entryNow;
    wire        returnStart;
    wire        restoreNow;
    wire [1:0]  cycles;
    wire [7:0]  adjSum;

    assign isIdle      = (state_reg == ST_IDLE);
    assign isReturn    = opValid && (opcode == `ICR_OP_RETURN);
    assign isReturnAdj = opValid && (opcode == `ICR_OP_RETURN_ADJ);

    // an interrupt is only taken from idle; while busy the core is
    // expected to hold it off, so one arriving then leaves no trace
    assign entryNow    = isIdle && irqTake;
    // interrupt entry beats a return decoded in the same cycle
    assign returnStart = isIdle && !irqTake && (isReturn || isReturnAdj);
    // last cycle of a return: the context goes back at this edge
    assign restoreNow  = (state_reg == ST_RETURN) && (cnt_reg == 2'h1);

    // turbo is sampled at decode only; a change mid-return is ignored
    assign cycles = turboMode ? `ICR_CYC_TURBO : `ICR_CYC_COMPAT;

    // 8-bit sum drops the carry on purpose: the counter wraps and no
    // flag sees it, since status is reloaded wholesale afterwards
    assign adjSum = realTimeCounterIn + accIn;

    // sequencer: counts the cycles of a return and raises busy
    always @* begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        busy_next  = busy;
        case (state_reg)
            ST_IDLE: begin
                if (returnStart) begin
                    // the decode cycle counts as the first cycle
                    cnt_next   = cycles - 2'h1;
                    busy_next  = 1'b1;
                    state_next = ST_RETURN;
                end
            end
            ST_RETURN: begin
                cnt_next = cnt_reg - 2'h1;
                if (restoreNow) begin
                    // busy drops on the edge the restore pulses rise
                    busy_next  = 1'b0;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                // an illegal code falls back to idle with no pulse
                cnt_next   = `ICR_RST_CNT;
                busy_next  = `ICR_RST_BIT;
                state_next = ST_IDLE;
            end
        endcase
    end

    // shadow capture: every interrupt taken re-saves the whole context,
    // so back-to-back entries keep only the latest one
    always @* begin
        shadowPc_next      = shadowPc_reg;
        shadowAcc_next     = shadowAcc_reg;
        shadowStatus_next  = shadowStatus_reg;
        shadowPointer_next = shadowPointer_reg;
        if (entryNow) begin
            shadowPc_next      = pcIn;
            shadowAcc_next     = accIn;
            shadowStatus_next  = statusIn;
            shadowPointer_next = fileSelectIn;
        end
    end

    // fetch redirect: vector on entry, saved pc at the end of a return;
    // the two never meet, as entry is only taken from idle
    always @* begin
        fetchLoad_next = 1'b0;
        fetchAddr_next = fetchAddr;
        if (entryNow) begin
            fetchLoad_next = 1'b1;
            fetchAddr_next = `ICR_VECTOR_ADDR;
        end else if (restoreNow) begin
            fetchLoad_next = 1'b1;
            fetchAddr_next = shadowPc_reg;
        end
    end

    // context restore: status comes back whole, no flag is recomputed
    always @* begin
        restoreLoad_next   = 1'b0;
        accOut_next        = accOut;
        statusOut_next     = statusOut;
        fileSelectOut_next = fileSelectOut;
        if (restoreNow) begin
            restoreLoad_next   = 1'b1;
            accOut_next        = shadowAcc_reg;
            statusOut_next     = shadowStatus_reg;
            fileSelectOut_next = shadowPointer_reg;
        end
    end

    // counter adjust at the start of the sequence, using the live
    // accumulator before the restore overwrites it; the core must not
    // write the counter itself in that cycle
    always @* begin
        realTimeCounterLoad_next = 1'b0;
        realTimeCounterOut_next  = realTimeCounterOut;
        if (returnStart && isReturnAdj) begin
            realTimeCounterLoad_next = 1'b1;
            realTimeCounterOut_next  = adjSum;
        end
    end

    // sequencer registers
    always @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= `ICR_RST_CNT;
            busy      <= `ICR_RST_BIT;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            busy      <= busy_next;
        end
    end

    // shadow registers; cleared by reset so a stray return restores
    // zeros rather than unknowns
    always @(posedge clk) begin
        if (!reset_n) begin
            shadowPc_reg      <= `ICR_RST_PC;
            shadowAcc_reg     <= `ICR_RST_BYTE;
            shadowStatus_reg  <= `ICR_RST_BYTE;
            shadowPointer_reg <= `ICR_RST_BYTE;
        end else begin
            shadowPc_reg      <= shadowPc_next;
            shadowAcc_reg     <= shadowAcc_next;
            shadowStatus_reg  <= shadowStatus_next;
            shadowPointer_reg <= shadowPointer_next;
        end
    end

    // output registers: every output comes straight from a flip-flop
    always @(posedge clk) begin
        if (!reset_n) begin
            fetchLoad           <= `ICR_RST_BIT;
            fetchAddr           <= `ICR_RST_PC;
            restoreLoad         <= `ICR_RST_BIT;
            accOut              <= `ICR_RST_BYTE;
            statusOut           <= `ICR_RST_BYTE;
            fileSelectOut       <= `ICR_RST_BYTE;
            realTimeCounterLoad <= `ICR_RST_BIT;
            realTimeCounterOut  <= `ICR_RST_BYTE;
        end else begin
            fetchLoad           <= fetchLoad_next;
            fetchAddr           <= fetchAddr_next;
            restoreLoad         <= restoreLoad_next;
            accOut              <= accOut_next;
            statusOut           <= statusOut_next;
            fileSelectOut       <= fileSelectOut_next;
            realTimeCounterLoad <= realTimeCounterLoad_next;
            realTimeCounterOut  <= realTimeCounterOut_next;
        end
    end

endmodule // interrupt_context_return

//--- sim/interrupt_context_return_monitor.sv
// checker: entry and return timing of the block
// assumes it is bound onto interrupt_context_return
`timescale 1ns/1ps
module interrupt_context_return_monitor (
    input wire clk, reset_n, turboMode, irqTake, opValid, fetchLoad,
    input wire restoreLoad, realTimeCounterLoad, busy,
    input wire [11:0] opcode, fetchAddr,
    input wire [7:0] accIn, realTimeCounterIn, realTimeCounterOut
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // a decode counts only when irq and busy leave the cycle free
    wire d = opValid && !busy && !irqTake;
    wire r = d && opcode == 12'h00e;
    wire w = d && opcode == 12'h00f;
    property p_v; irqTake && !busy |=> fetchLoad && !fetchAddr; endproperty
    a_v: assert property (p_v) else $error("vector");
    property p_c; (r || w) && !turboMode |=> busy ##1 restoreLoad; endproperty
    a_c: assert property (p_c) else $error("compat");
    property p_t; (r || w) && turboMode |=> busy[*2] ##1 restoreLoad; endproperty
    a_t: assert property (p_t) else $error("turbo");
    property p_s; w |=> realTimeCounterLoad && realTimeCounterOut ==
        8'($past(realTimeCounterIn) + $past(accIn)); endproperty
    a_s: assert property (p_s) else $error("counter sum");
    property p_n; r |=> !realTimeCounterLoad; endproperty
    a_n: assert property (p_n) else $error("counter load");
    property p_f; restoreLoad |-> fetchLoad && !busy; endproperty
    a_f: assert property (p_f) else $error("resume");
    property p_b; restoreLoad |-> $past(busy); endproperty
    a_b: assert property (p_b) else $error("restore");
    // an irq inside a return must leave no fetch trace
    property p_i; busy |=> !fetchLoad || restoreLoad; endproperty
    a_i: assert property (p_i) else $error("irq in return");
    c_w: cover property (w && turboMode);
    c_c: cover property (w && !turboMode);
    c_r: cover property (r);
    c_i: cover property (irqTake && !busy);
endmodule // interrupt_context_return_monitor
bind interrupt_context_return interrupt_context_return_monitor i_mon (
    .clk(clk), .reset_n(reset_n), .turboMode(turboMode),
    .irqTake(irqTake), .opValid(opValid), .fetchLoad(fetchLoad),
    .restoreLoad(restoreLoad), .realTimeCounterLoad(realTimeCounterLoad),
    .busy(busy), .opcode(opcode), .fetchAddr(fetchAddr), .accIn(accIn),
    .realTimeCounterIn(realTimeCounterIn),
    .realTimeCounterOut(realTimeCounterOut)
);

//--- sim/interrupt_context_return_tb.sv
// bench: irq entry, then both returns in both timing modes
// assumes design and monitor are compiled before it
`timescale 1ns/1ps
module interrupt_context_return_tb;
    reg clk = 0, reset_n = 0, turboMode = 0, irqTake = 0, opValid = 0;
    reg [11:0] pcIn = 0, opcode = 0;
    reg [7:0] accIn = 0, statusIn = 0, fileSelectIn = 0;
    reg [7:0] realTimeCounterIn = 8'hf0;
    wire fetchLoad, restoreLoad, realTimeCounterLoad, busy;
    wire [11:0] fetchAddr;
    wire [7:0] accOut, statusOut, fileSelectOut, realTimeCounterOut;
    int fail_count = 0, tests_run = 0;
    interrupt_context_return i_dut (
        .clk(clk), .reset_n(reset_n), .turboMode(turboMode),
        .irqTake(irqTake), .pcIn(pcIn), .accIn(accIn),
        .statusIn(statusIn), .fileSelectIn(fileSelectIn),
        .realTimeCounterIn(realTimeCounterIn), .opValid(opValid),
        .opcode(opcode), .fetchLoad(fetchLoad), .fetchAddr(fetchAddr),
        .restoreLoad(restoreLoad), .accOut(accOut),
        .statusOut(statusOut), .fileSelectOut(fileSelectOut),
        .realTimeCounterLoad(realTimeCounterLoad),
        .realTimeCounterOut(realTimeCounterOut), .busy(busy)
    );
    initial forever #4 clk = ~clk;
    task step; @(posedge clk); #1; endtask
    task chk(string n, logic [11:0] e, logic [11:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task chk1(string n, logic e, logic g);
        chk(n, {11'h0, e}, {11'h0, g});
    endtask
    task chk8(string n, logic [7:0] e, logic [7:0] g);
        chk(n, {4'h0, e}, {4'h0, g});
    endtask
    // live state moves after entry, so a restore must come from shadows
    task t_entry;
        {pcIn, accIn, statusIn, fileSelectIn} = 36'h5a3c41f27;
        irqTake = 1'b1;
        step;
        irqTake = 1'b0;
        // the service routine leaves the counter correction in the acc
        {pcIn, accIn, statusIn, fileSelectIn} = 36'h0ff350000;
        chk1("fetchLoad", 1'b1, fetchLoad);
        chk("fetchAddr", 12'h000, fetchAddr);
    endtask
    // turbo also offers an irq and a second return while busy
    task t_ret(logic t, logic [11:0] op);
        logic [7:0] sum;
        sum = realTimeCounterIn + 8'h35; // wraps mod 256
        {turboMode, opValid, opcode} = {t, 1'b1, op};
        step;
        {opValid, irqTake} = {t, t};
        chk1("busy", 1'b1, busy);
        chk1("rtcLoad", op[0], realTimeCounterLoad);
        if (op[0]) chk8("rtcOut", sum, realTimeCounterOut);
        step;
        {opValid, irqTake} = 2'h0;
        if (t) chk1("early", 1'b0, restoreLoad);
        if (t) step;
        chk1("restore", 1'b1, restoreLoad & fetchLoad);
        chk1("busy", 1'b0, busy);
        chk("pc", 12'h5a3, fetchAddr);
        chk8("acc", 8'hc4, accOut);
        chk8("status", 8'h1f, statusOut);
        chk8("pointer", 8'h27, fileSelectOut);
    endtask
    // a mid-run reset drops a return under way and clears every output
    task t_reset;
        {turboMode, opValid, opcode} = {1'b1, 1'b1, 12'h00f};
        step;
        {opValid, reset_n} = 2'h0;
        step;
        step;
        reset_n = 1'b1;
        chk1("busy", 1'b0, busy);
        chk1("fetchLoad", 1'b0, fetchLoad);
        chk("fetchAddr", 12'h000, fetchAddr);
        chk1("restore", 1'b0, restoreLoad);
        chk8("acc", 8'h00, accOut);
        chk8("status", 8'h00, statusOut);
        chk8("pointer", 8'h00, fileSelectOut);
        chk1("rtcLoad", 1'b0, realTimeCounterLoad);
        chk8("rtcOut", 8'h00, realTimeCounterOut);
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1 reset_n = 1'b1;
        t_entry;
        t_ret(0, 12'h00e);
        t_entry;
        t_ret(1, 12'h00f);
        t_entry;
        realTimeCounterIn = 8'hd0; // a second counter value
        t_ret(0, 12'h00f);
        t_reset;
        t_entry;
        t_ret(1, 12'h00e);
        report_and_stop;
    end
    // hang guard, far beyond the few dozen cycles the run needs
    initial begin
        #5000;
        fail_count++;
        report_and_stop;
    end
endmodule // interrupt_context_return_tb
